/* obd_decoder.sv */
// Purpose: Loads the option bytes at reset and decodes them into settings.
// Assumes: Programmer writes arrive as single-cycle strobes on i_prog_wr.
// Notes:   Settings are sampled once per reset and then held unchanged.
`default_nettype none
module obd_decoder (
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_por_n,
	input  wire logic                  i_in_circuit_programming,
	input  wire logic                  i_single_wire_debug_access,
	input  wire logic                  i_prog_wr,
	input  wire logic [15:0]           i_prog_addr,
	input  wire logic [obd_pkg::ROW_DW-1:0] i_prog_wdata,
	output logic                       o_prog_ack,
	output logic                       o_prog_err,
	output logic                       o_cfg_valid,
	output logic                       o_readout_protect,
	output logic [6:0]                 o_boot_area_size,
	output logic                       o_boot_vectors_only,
	output logic                       o_boot_write_protect,
	output logic [5:0]                 o_data_area_size,
	output logic                       o_data_area_en,
	output logic [15:0]                o_data_area_base,
	output logic                       o_watchdog_hw_start,
	output logic                       o_watchdog_halt_stop,
	output logic                       o_cfg_invalid
);
	import obd_pkg::*;

	// Maps a byte address to its row slot; only documented bytes are writable.
	function automatic logic mapped(input logic [15:0] a);
		return a == READOUT_OFS || a == BOOT_AREA_OFS || a == DATA_AREA_OFS ||
			a == RESERVED_OFS || a == WATCHDOG_OFS;
	endfunction

	function automatic logic [ROW_AW-1:0] slot(input logic [15:0] a);
		logic [15:0] d;
		d = a - ROW_BASE;
		return d[ROW_AW-1:0];
	endfunction

	function automatic logic [15:0] load_addr(input logic [2:0] s);
		case (s)
			3'h0:    return READOUT_OFS;
			3'h1:    return BOOT_AREA_OFS;
			3'h2:    return DATA_AREA_OFS;
			3'h3:    return RESERVED_OFS;
			default: return WATCHDOG_OFS;
		endcase
	endfunction

	obd_row_if row ();

	obd_option_row #(
		.DEPTH (ROW_DEPTH)
	) u_row (
		.i_core_clk (i_core_clk),
		.i_por_n    (i_por_n),
		.row        (row)
	);

	// Programming path.
	logic write_ok;
	logic ack_d;
	logic ack_q;
	logic err_d;
	logic err_q;

	always_comb begin
		write_ok  = i_prog_wr && i_rst_n && i_in_circuit_programming &&
			i_single_wire_debug_access && mapped(i_prog_addr);
		ack_d     = write_ok;
		err_d     = i_prog_wr && i_rst_n && !write_ok;
		row.we    = write_ok;
		row.waddr = slot(i_prog_addr);
		row.wdata = i_prog_wdata;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			ack_q <= ack_d;
			err_q <= err_d;
		end
	end

	// Load sequencer: steps 0..4 read, steps 1..5 capture, step 6 publishes.
	obd_state_e        state_d, state_q;
	logic [2:0]        step_d, step_q;
	logic [ROW_DW-1:0] raw_d [LOAD_BYTES];
	logic [ROW_DW-1:0] raw_q [LOAD_BYTES];
	logic              pub_d, pub_q;

	always_comb begin
		state_d   = state_q;
		step_d    = step_q;
		raw_d     = raw_q;
		pub_d     = 1'b0;
		row.raddr = slot(load_addr(step_q));
		case (state_q)
			OBD_LOAD: begin
				// The publish step has no byte left to capture, so it must not index past the end.
				if (step_q != 3'h0 && step_q != LOAD_LAST_STEP) begin
					raw_d[step_q - 3'h1] = row.rdata;
				end
				if (step_q == LOAD_LAST_STEP) begin
					state_d = OBD_DONE;
					pub_d   = 1'b1;
				end else begin
					step_d = step_q + 3'h1;
				end
			end
			OBD_DONE: begin
				state_d = OBD_DONE;
			end
			default: begin
				state_d = OBD_LOAD;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state_q <= OBD_LOAD;
			step_q  <= 3'h0;
			pub_q   <= 1'b0;
			for (int i = 0; i < LOAD_BYTES; i++) begin
				raw_q[i] <= OPTION_RESET;
			end
		end else begin
			state_q <= state_d;
			step_q  <= step_d;
			pub_q   <= pub_d;
			raw_q   <= raw_d;
		end
	end

	// Decode of the captured bytes into the next settings.
	logic [6:0]  boot_pages;
	logic [5:0]  data_pages;
	logic [15:0] data_span;
	logic        valid_d;
	logic        readout_d;
	logic [6:0]  boot_size_d;
	logic        boot_vec_d;
	logic        boot_wp_d;
	logic [5:0]  data_size_d;
	logic        data_en_d;
	logic [15:0] data_base_d;
	logic        wdg_hw_d;
	logic        wdg_halt_d;
	logic        invalid_d;

	// Settings move only on the publish step; a byte written later waits for the next reset.
	always_comb begin
		boot_pages  = raw_q[1][6:0];
		data_pages  = raw_q[2][5:0];
		data_span   = {4'h0, data_pages, 6'h00};
		valid_d     = o_cfg_valid;
		readout_d   = o_readout_protect;
		boot_size_d = o_boot_area_size;
		boot_vec_d  = o_boot_vectors_only;
		boot_wp_d   = o_boot_write_protect;
		data_size_d = o_data_area_size;
		data_en_d   = o_data_area_en;
		data_base_d = o_data_area_base;
		wdg_hw_d    = o_watchdog_hw_start;
		wdg_halt_d  = o_watchdog_halt_stop;
		invalid_d   = o_cfg_invalid;
		if (pub_d) begin
			valid_d     = 1'b1;
			readout_d   = raw_q[0] == READOUT_KEY;
			boot_size_d = boot_pages;
			boot_vec_d  = boot_pages != BOOT_NONE && boot_pages <= BOOT_VEC_MAX;
			boot_wp_d   = boot_pages > BOOT_VEC_MAX;
			data_size_d = data_pages;
			data_en_d   = data_pages != DATA_NONE;
			data_base_d = DATA_TOP + 16'h0001 - data_span;
			wdg_hw_d    = raw_q[4][WDG_HW_BIT];
			wdg_halt_d  = raw_q[4][WDG_HALT_BIT];
			invalid_d   = raw_q[3] != RESERVED_REQUIRED;
		end
	end

	// Outputs are held until reset; readout protection is asserted while loading as the safe state.
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_cfg_valid          <= 1'b0;
			o_readout_protect    <= 1'b1;
			o_boot_area_size     <= BOOT_NONE;
			o_boot_vectors_only  <= 1'b0;
			o_boot_write_protect <= 1'b0;
			o_data_area_size     <= DATA_NONE;
			o_data_area_en       <= 1'b0;
			o_data_area_base     <= DATA_TOP + 16'h0001;
			o_watchdog_hw_start  <= 1'b0;
			o_watchdog_halt_stop <= 1'b0;
			o_cfg_invalid        <= 1'b0;
		end else begin
			o_cfg_valid          <= valid_d;
			o_readout_protect    <= readout_d;
			o_boot_area_size     <= boot_size_d;
			o_boot_vectors_only  <= boot_vec_d;
			o_boot_write_protect <= boot_wp_d;
			o_data_area_size     <= data_size_d;
			o_data_area_en       <= data_en_d;
			o_data_area_base     <= data_base_d;
			o_watchdog_hw_start  <= wdg_hw_d;
			o_watchdog_halt_stop <= wdg_halt_d;
			o_cfg_invalid        <= invalid_d;
		end
	end

	assign o_prog_ack = ack_q;
	assign o_prog_err = err_q;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_refused_write;
		i_prog_wr && !(i_in_circuit_programming && i_single_wire_debug_access);
	endsequence

	sequence s_taken_write;
		i_prog_wr && i_in_circuit_programming && i_single_wire_debug_access &&
			mapped(i_prog_addr);
	endsequence

	sequence s_load_window;
		!o_cfg_valid [*7] ##1 o_cfg_valid;
	endsequence

	// Every strobe outside reset is answered by exactly one of ack or err a cycle later.
	a_refused_write_err: assert property (s_refused_write |=> !o_prog_ack && o_prog_err)
		else $error("write outside programming mode was taken");
	a_taken_write_ack: assert property (s_taken_write |=> o_prog_ack && !o_prog_err)
		else $error("accepted write was not acknowledged");
	a_unmapped_write_err: assert property (i_prog_wr && !mapped(i_prog_addr) |=>
		!o_prog_ack && o_prog_err)
		else $error("write to unmapped byte was not refused");
	a_ack_err_apart: assert property (o_prog_ack |-> !o_prog_err)
		else $error("write both taken and refused");
	a_readout_key_decode: assert property (o_cfg_valid |->
		o_readout_protect == (raw_q[0] == READOUT_KEY))
		else $error("readout protection does not match key byte");
	a_boot_none_empty: assert property (o_cfg_valid && o_boot_area_size == BOOT_NONE |->
		!o_boot_vectors_only && !o_boot_write_protect)
		else $error("empty boot area shows protection");
	a_boot_vectors_span: assert property (o_cfg_valid |->
		o_boot_vectors_only == (o_boot_area_size != 7'h00 && o_boot_area_size <= 7'h02))
		else $error("vectors-only flag wrong for boot size");
	a_boot_protect_span: assert property (o_cfg_valid |->
		o_boot_write_protect == (o_boot_area_size >= 7'h03))
		else $error("boot area protection wrong for size");
	a_boot_msb_mask: assert property (o_cfg_valid |->
		o_boot_area_size == raw_q[1][6:0])
		else $error("boot size not masked copy of stored byte");
	a_data_base_calc: assert property (o_cfg_valid && o_data_area_en |->
		o_data_area_base == 16'ha000 - 16'(o_data_area_size) * 16'h0040)
		else $error("data area base wrong");
	a_data_none_off: assert property (o_cfg_valid |->
		o_data_area_en == (raw_q[2][5:0] != 6'h00))
		else $error("data area enable wrong");
	a_data_msb_mask: assert property (o_cfg_valid |->
		o_data_area_size == raw_q[2][5:0])
		else $error("data size not masked copy of stored byte");
	a_watchdog_bits: assert property (o_cfg_valid |->
		o_watchdog_hw_start == raw_q[4][0] && o_watchdog_halt_stop == raw_q[4][1])
		else $error("watchdog option bits wrong");
	a_reserved_invalid: assert property (o_cfg_valid |->
		o_cfg_invalid == (raw_q[3] != 8'h00))
		else $error("invalid flag does not follow reserved byte");
	// Until the load completes, readout protection stays on so that nothing leaks early.
	a_protect_loading: assert property (!o_cfg_valid |-> o_readout_protect)
		else $error("readout protection dropped before settings loaded");
	a_load_after_reset: assert property ($rose(i_rst_n) |-> s_load_window)
		else $error("settings not published seven clocks after reset");
	a_settings_hold: assert property (o_cfg_valid |=> o_cfg_valid &&
		$stable(o_readout_protect) && $stable(o_boot_area_size) &&
		$stable(o_data_area_base) && $stable(o_watchdog_hw_start))
		else $error("settings changed before next reset");
	a_other_hold: assert property (o_cfg_valid |=> $stable(o_boot_write_protect) &&
		$stable(o_data_area_en) && $stable(o_watchdog_halt_stop) && $stable(o_cfg_invalid))
		else $error("decoded flags changed before next reset");
endmodule : obd_decoder
`default_nettype wire

/* obd_pkg.sv */
// Purpose: Shared constants and types of the configuration byte decoder.
// Assumes: Configuration bytes live in one row of nine byte slots.
// Notes:   Slot index is the byte address minus the row base.
`default_nettype none
package obd_pkg;
	localparam int          ROW_AW           = 4;
	localparam int          ROW_DW           = 8;
	localparam int          ROW_DEPTH        = 9;
	localparam int          LOAD_BYTES       = 5;
	localparam logic [15:0] ROW_BASE         = 16'h4800;
	localparam logic [15:0] READOUT_OFS      = 16'h4800;
	localparam logic [15:0] BOOT_AREA_OFS    = 16'h4802;
	localparam logic [15:0] DATA_AREA_OFS    = 16'h4803;
	localparam logic [15:0] RESERVED_OFS     = 16'h4807;
	localparam logic [15:0] WATCHDOG_OFS     = 16'h4808;
	localparam logic [7:0]  OPTION_RESET     = 8'h00;
	localparam logic [7:0]  READOUT_KEY      = 8'haa;
	localparam logic [7:0]  RESERVED_REQUIRED = 8'h00;
	localparam logic [6:0]  BOOT_VEC_MAX     = 7'h02;
	localparam logic [6:0]  BOOT_NONE        = 7'h00;
	localparam logic [5:0]  DATA_NONE        = 6'h00;
	localparam logic [15:0] DATA_TOP         = 16'h9fff;
	localparam int          PAGE_SHIFT       = 6;
	localparam int          WDG_HW_BIT       = 0;
	localparam int          WDG_HALT_BIT     = 1;
	localparam logic [2:0]  LOAD_LAST_STEP   = 3'h6;
	typedef enum logic [0:0] {OBD_LOAD, OBD_DONE} obd_state_e;
endpackage : obd_pkg
`default_nettype wire

/* obd_row_if.sv */
// Purpose: Carrier between the decoder and its option row memory.
// Assumes: One write port and one registered read port.
// Notes:   Read data appear one clock after the read address.
`default_nettype none
interface obd_row_if;
	import obd_pkg::*;
	logic              we;
	logic [ROW_AW-1:0] waddr;
	logic [ROW_DW-1:0] wdata;
	logic [ROW_AW-1:0] raddr;
	logic [ROW_DW-1:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : obd_row_if
`default_nettype wire

/* obd_option_row.sv */
// Purpose: Non-volatile option row holding the configuration bytes.
// Assumes: i_por_n models a fresh part and restores the factory values.
// Notes:   Device reset does not touch the contents, as the row is non-volatile.
`default_nettype none
module obd_option_row #(
	parameter int DEPTH = obd_pkg::ROW_DEPTH
) (
	input  wire logic i_core_clk,
	input  wire logic i_por_n,
	obd_row_if.mem    row
);
	import obd_pkg::*;
	logic [ROW_DW-1:0] mem_q [DEPTH];
	logic [ROW_DW-1:0] rdata_d;
	logic [ROW_DW-1:0] rdata_q;

	always_comb begin
		rdata_d = OPTION_RESET;
		if (int'(row.raddr) < DEPTH) begin
			rdata_d = mem_q[row.raddr];
		end
	end

	always_ff @(posedge i_core_clk) begin
		rdata_q <= rdata_d;
		for (int i = 0; i < DEPTH; i++) begin
			if (!i_por_n) begin
				mem_q[i] <= OPTION_RESET;
			end else if (row.we && int'(row.waddr) == i) begin
				mem_q[i] <= row.wdata;
			end
		end
	end

	assign row.rdata = rdata_q;
endmodule : obd_option_row
`default_nettype wire

/* obd_prog_model.sv */
// Purpose: Programmer model that writes option bytes over the debug wire.
// Assumes: It drives at the falling edge; the decoder answers one cycle later.
// Notes:   A released address or data bus shows the inverse of its last value.
`default_nettype none
module obd_prog_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_prog_ack,
	input  wire logic        i_prog_err,
	output logic             o_icp,
	output logic             o_swd,
	output logic             o_wr,
	output logic [15:0]      o_addr,
	output logic [7:0]       o_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_icp = 1'b0;
		o_swd = 1'b0;
		o_wr = 1'b0;
		o_addr = 16'h0000;
		o_wdata = 8'h00;
	end
	// Callers keep the reserved byte at zero except where the invalid flag is probed.
	task automatic put(input logic [15:0] a, input logic [7:0] d, input logic m,
		input logic s, output logic ack, output logic err);
		@(negedge i_core_clk);
		o_icp = m;
		o_swd = s;
		o_wr = 1'b1;
		o_addr = a;
		o_wdata = d;
		@(negedge i_core_clk);
		ack = i_prog_ack;
		err = i_prog_err;
		o_wr = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask
endmodule // obd_prog_model
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench of the option byte decoder.
// Assumes: Row is cleared by power-on reset once at the start.
// Notes:   Every decode case but an empty boot area is written, then seen after a device reset.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import obd_pkg::*;
	logic        i_core_clk, i_rst_n, i_por_n, in_circuit_programming, swd, wr, ack, err, valid, rp;
	logic        vec, wp, den, hw, halt, inv, k, e;
	logic [15:0] addr, base;
	logic [7:0]  wdata;
	logic [6:0]  bsz;
	logic [5:0]  dsz;
	int          num_errors, tests_run;
	logic [15:0] ofs [5] = '{READOUT_OFS, BOOT_AREA_OFS, DATA_AREA_OFS, WATCHDOG_OFS,
		RESERVED_OFS};
	logic [7:0]  tv [4][5] = '{'{8'haa, 8'h01, 8'h01, 8'h01, 8'h00},
		'{8'hab, 8'h03, 8'h20, 8'h02, 8'h00}, '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00},
		'{8'h55, 8'hff, 8'hff, 8'h03, 8'h07}};
	obd_decoder uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n),
		.i_in_circuit_programming(in_circuit_programming), .i_single_wire_debug_access(swd), .i_prog_wr(wr),
		.i_prog_addr(addr), .i_prog_wdata(wdata), .o_prog_ack(ack), .o_prog_err(err),
		.o_cfg_valid(valid), .o_readout_protect(rp), .o_boot_area_size(bsz),
		.o_boot_vectors_only(vec), .o_boot_write_protect(wp), .o_data_area_size(dsz),
		.o_data_area_en(den), .o_data_area_base(base), .o_watchdog_hw_start(hw),
		.o_watchdog_halt_stop(halt), .o_cfg_invalid(inv));
	obd_prog_model prog (.i_core_clk(i_core_clk), .i_prog_ack(ack), .i_prog_err(err),
		.o_icp(in_circuit_programming), .o_swd(swd), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
	initial begin
		i_core_clk = 1'b0;
		forever #10 i_core_clk = ~i_core_clk;
	end
	task automatic complete_run;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
		tests_run++;
		if (g !== x) begin
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
			num_errors++;
		end
	endtask
	// Settings are captured only here, 7 edges after release, so writes wait for it.
	task automatic do_reset(input logic por);
		@(negedge i_core_clk);
		i_rst_n = 1'b0;
		i_por_n = ~por;
		repeat (10) @(negedge i_core_clk);
		chk("rp_in_reset", 1'b1, rp);
		chk("base_in_reset", 16'ha000, base);
		i_por_n = 1'b1;
		i_rst_n = 1'b1;
		repeat (6) @(negedge i_core_clk);
		chk("valid_early", 1'b0, valid);
		@(negedge i_core_clk);
		chk("valid", 1'b1, valid);
	endtask
	task automatic wr_ok(input logic [15:0] a, input logic [7:0] d);
		prog.put(a, d, 1'b1, 1'b1, k, e);
		chk("ack", 1'b1, k);
		chk("err", 1'b0, e);
	endtask
	task automatic check_cfg(input logic [7:0] r, b, d, w, z);
		logic [6:0] bx;
		logic [5:0] dx;
		bx = b[6:0];
		dx = d[5:0];
		chk("readout", r == READOUT_KEY, rp);
		chk("boot_size", bx, bsz);
		chk("boot_vec", bx != 7'h00 && bx <= BOOT_VEC_MAX, vec);
		chk("boot_wp", bx > BOOT_VEC_MAX, wp);
		chk("data_size", dx, dsz);
		chk("data_en", dx != 6'h00, den);
		chk("data_base", 16'ha000 - {4'h0, dx, 6'h00}, base);
		chk("wdg_hw", w[0], hw);
		chk("wdg_halt", w[1], halt);
		chk("invalid", z != 8'h00, inv);
	endtask
	task automatic test_fresh;
		do_reset(1'b1);
		check_cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
	endtask
	task automatic test_refused;
		prog.put(WATCHDOG_OFS, 8'h03, 1'b0, 1'b1, k, e);
		chk("err_no_mode", 2'b01, {k, e});
		prog.put(WATCHDOG_OFS, 8'h03, 1'b1, 1'b0, k, e);
		chk("err_no_wire", 2'b01, {k, e});
		prog.put(16'h4801, 8'haa, 1'b1, 1'b1, k, e);
		chk("err_unmapped", 2'b01, {k, e});
		do_reset(1'b0);
		check_cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
	endtask
	task automatic test_decode;
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 5; j++) begin
				wr_ok(ofs[j], tv[i][j]);
			end
			do_reset(1'b0);
			check_cfg(tv[i][0], tv[i][1], tv[i][2], tv[i][3], tv[i][4]);
		end
	endtask
	task automatic test_hold;
		wr_ok(WATCHDOG_OFS, 8'h00);
		repeat (3) @(negedge i_core_clk);
		chk("wdg_held", 2'b11, {halt, hw});
		do_reset(1'b0);
		chk("wdg_new", 2'b00, {halt, hw});
	endtask
	// A write made while the device sits in reset is dropped with no answer.
	task automatic test_reset_write;
		@(negedge i_core_clk);
		i_rst_n = 1'b0;
		prog.put(WATCHDOG_OFS, 8'h03, 1'b1, 1'b1, k, e);
		chk("reset_write", 2'b00, {k, e});
		do_reset(1'b0);
		chk("reset_write_kept", 2'b00, {halt, hw});
	endtask
	initial begin
		num_errors = 0;
		tests_run = 0;
		i_rst_n = 1'b0;
		i_por_n = 1'b0;
		test_fresh();
		test_refused();
		test_decode();
		test_hold();
		test_reset_write();
		complete_run();
	end
	initial begin
		#100000;
		num_errors++;
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
